// file: common/iocbd_defs.vh
/*
 * Constants for the control block decoder: word indices, field positions,
 * control-field patterns and status codes.
 * Assumes 48-bit memory words and inclusion by bare name.
 */
`ifndef IOCBD_DEFS_VH
`define IOCBD_DEFS_VH

`define IOCBD_WORD_W 48
`define IOCBD_ADDR_W 20
`define IOCBD_LEN_W 16
`define IOCBD_WIDX_W 4

// ****************************************************************
// Control block word indices
// ****************************************************************
`define IOCBD_W_CTRL 4'h0
`define IOCBD_W_ADDR 4'h1
`define IOCBD_W_COMMAND_QUEUE_HEADER_PTR 4'h2
`define IOCBD_W_SELF 4'h3
`define IOCBD_W_CMDP 4'h4
`define IOCBD_W_RESP 4'h5
`define IOCBD_W_LEN 4'h6
`define IOCBD_W_MASK 4'h7
`define IOCBD_W_RESULT_QUEUE_HEAD_PTR 4'h8
`define IOCBD_W_LINK 4'h9

// ****************************************************************
// Control word fields
// ****************************************************************
`define IOCBD_CW_W 18
`define IOCBD_CW_INTERNAL 1
`define IOCBD_CW_INPUT 5
`define IOCBD_CW_OUTPUT 6

// Patterns as {care mask, required value} over bits 17..0.
`define IOCBD_NPAT 13
// The internal and test patterns leave the attention bit free.
`define IOCBD_PAT_OP_M 18'h077E2
`define IOCBD_PAT_OP_V 18'h00402
`define IOCBD_PAT_TS_M 18'h077E2
`define IOCBD_PAT_TS_V 18'h00400
`define IOCBD_PAT_I0_M 18'h09FF2
`define IOCBD_PAT_I0_V 18'h00930
`define IOCBD_PAT_I1_V 18'h00A30
`define IOCBD_PAT_I2_M 18'h087E2
`define IOCBD_PAT_I2_V 18'h00420
`define IOCBD_PAT_I3_V 18'h00620
`define IOCBD_PAT_I4_V 18'h00720
`define IOCBD_PAT_O0_M 18'h0BFF2
`define IOCBD_PAT_O0_V 18'h00950
`define IOCBD_PAT_O1_V 18'h00A50
`define IOCBD_PAT_O2_M 18'h0B7E2
`define IOCBD_PAT_O2_V 18'h00440
`define IOCBD_PAT_O3_V 18'h004C0
`define IOCBD_PAT_EC_V 18'h00460

// ****************************************************************
// Link address word fields
// ****************************************************************
`define IOCBD_AW_PORT_HI 19
`define IOCBD_AW_PORT_LO 16
`define IOCBD_AW_BASE 15
`define IOCBD_AW_EXP 14
`define IOCBD_AW_MOD_HI 7
`define IOCBD_AW_MOD_LO 4
`define IOCBD_AW_SLOT_HI 3
`define IOCBD_AW_SLOT_LO 0
`define IOCBD_AW_USED 48'h00000000C0FF
`define IOCBD_AW_PORTM 48'h0000000F0000

// Self pointer operand markers and length fields.
`define IOCBD_SELF_NULL 48'h000000000000
`define IOCBD_SELF_INIT 48'h000000000001
`define IOCBD_LEN_CMD_HI 47
`define IOCBD_LEN_CMD_LO 32
`define IOCBD_LEN_RES_HI 15
`define IOCBD_LEN_RES_LO 0

// ****************************************************************
// Error codes
// ****************************************************************
`define IOCBD_ERR_NONE 3'h0
`define IOCBD_ERR_CMD 3'h1
`define IOCBD_ERR_STATUS 3'h2
`define IOCBD_ERR_UNEXP 3'h3
`define IOCBD_ERR_ADDR 3'h4

`endif

// file: design/iocbd_cw_check.v
/*
 * Control-field pattern checker: matches the control word against the
 * table of accepted patterns and classifies the command.
 * Assumes a registered control word input; output is combinational.
 */
`timescale 1ns/1ps
`include "iocbd_defs.vh"
module iocbd_cw_check (
    input wire [`IOCBD_CW_W-1:0] control_word,
    output wire valid,
    output wire internal_operation,
    output wire echo
);
    // ****************************************************************
    // Pattern matching
    // ****************************************************************
    function match;
        input [`IOCBD_CW_W-1:0] cw;
        input [`IOCBD_CW_W-1:0] care;
        input [`IOCBD_CW_W-1:0] want;
        begin
            match = ((cw & care) == want);
        end
    endfunction

    wire op_hit = match(control_word, `IOCBD_PAT_OP_M, `IOCBD_PAT_OP_V);
    wire test_hit = match(control_word, `IOCBD_PAT_TS_M, `IOCBD_PAT_TS_V);
    wire in_hit = match(control_word, `IOCBD_PAT_I0_M, `IOCBD_PAT_I0_V)
        | match(control_word, `IOCBD_PAT_I0_M, `IOCBD_PAT_I1_V)
        | match(control_word, `IOCBD_PAT_I2_M, `IOCBD_PAT_I2_V)
        | match(control_word, `IOCBD_PAT_I2_M, `IOCBD_PAT_I3_V)
        | match(control_word, `IOCBD_PAT_I2_M, `IOCBD_PAT_I4_V);
    wire out_hit = match(control_word, `IOCBD_PAT_O0_M, `IOCBD_PAT_O0_V)
        | match(control_word, `IOCBD_PAT_O0_M, `IOCBD_PAT_O1_V)
        | match(control_word, `IOCBD_PAT_O2_M, `IOCBD_PAT_O2_V)
        | match(control_word, `IOCBD_PAT_O2_M, `IOCBD_PAT_O3_V);
    wire echo_hit = match(control_word, `IOCBD_PAT_O2_M, `IOCBD_PAT_EC_V);

    assign valid = op_hit | test_hit | in_hit | out_hit | echo_hit;
    assign internal_operation = control_word[`IOCBD_CW_INTERNAL];
    assign echo = echo_hit;
endmodule // iocbd_cw_check

// file: design/iocbd_addr_dec.v
/*
 * Link address word decoder: port, base card, expansion module and slot.
 * Assumes a stable registered address word; outputs are combinational.
 */
`timescale 1ns/1ps
`include "iocbd_defs.vh"
module iocbd_addr_dec (
    input wire [`IOCBD_WORD_W-1:0] link_address_word,
    output wire [3:0] port,
    output wire base_card_select,
    output wire expansion_module_select,
    output wire [3:0] expansion_module_number,
    output wire [3:0] link_slot_select,
    output wire malformed
);
    assign port = link_address_word[`IOCBD_AW_PORT_HI:`IOCBD_AW_PORT_LO];
    assign base_card_select = link_address_word[`IOCBD_AW_BASE];
    assign expansion_module_select = link_address_word[`IOCBD_AW_EXP];
    assign expansion_module_number =
        link_address_word[`IOCBD_AW_MOD_HI:`IOCBD_AW_MOD_LO];
    assign link_slot_select =
        link_address_word[`IOCBD_AW_SLOT_HI:`IOCBD_AW_SLOT_LO];
    // Values 8..F in a three-bit-range field are also rejected.
    assign malformed = ((link_address_word & ~(`IOCBD_AW_USED | `IOCBD_AW_PORTM))
            != {`IOCBD_WORD_W{1'b0}})
        | port[3] | expansion_module_number[3] | link_slot_select[3];
endmodule // iocbd_addr_dec

// file: design/iocbd_top.v
/*
 * Control block decoder: fetches the fixed-layout control block words
 * from memory, validates the control field, runs an internal operation or
 * a link command, bounds command and result transfers, masks status into
 * an interrupt sense, and links a completed link command's block onto a result queue.
 * Assumes a simple word memory port answering with mem_ack, and a
 * message link port on the same clock with valid/ready handshakes.
 */
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`include "iocbd_defs.vh"
module iocbd_top #(
    parameter AW = `IOCBD_ADDR_W,
    parameter LW = `IOCBD_LEN_W
) (
    input wire sys_clk,
    input wire rst_n,
    input wire start,
    input wire [AW-1:0] block_base,
    output wire busy,
    output reg done,
    output reg [2:0] error_code,
    output reg interrupt_sense,
    output reg mem_req,
    output reg mem_we,
    output reg [AW-1:0] mem_addr,
    output reg [`IOCBD_WORD_W-1:0] mem_wdata,
    input wire mem_ack,
    input wire [`IOCBD_WORD_W-1:0] mem_rdata,
    output reg link_connect,
    output reg link_hang,
    output reg [3:0] port,
    output reg base_card_select,
    output reg expansion_module_select,
    output reg [3:0] expansion_module_number,
    output reg [3:0] link_slot_select,
    output reg echo_command,
    output reg cmd_valid,
    output reg [`IOCBD_WORD_W-1:0] cmd_data,
    input wire cmd_ready,
    input wire res_valid,
    input wire [`IOCBD_WORD_W-1:0] res_data,
    input wire res_last,
    output wire res_ready,
    input wire link_status_ok,
    output reg [`IOCBD_WORD_W-1:0] internal_code,
    output reg internal_start,
    input wire [`IOCBD_WORD_W-1:0] state_result
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam S_IDLE = 4'h0;
    localparam S_FETCH = 4'h1;
    localparam S_CODE = 4'h2;
    localparam S_DECIDE = 4'h3;
    localparam S_CMD = 4'h4;
    localparam S_RES = 4'h5;
    localparam S_RESWR = 4'h6;
    localparam S_TAIL = 4'h7;
    localparam S_WALK = 4'h8;
    localparam S_LINK = 4'h9;
    localparam S_MARK = 4'hA;
    localparam S_DONE = 4'hB;

    reg [3:0] state;
    reg [`IOCBD_WIDX_W-1:0] widx;
    reg [`IOCBD_WORD_W-1:0] blk [0:9];
    reg [LW-1:0] count;
    reg [AW-1:0] cursor;
    reg [`IOCBD_WORD_W-1:0] res_hold;
    reg res_have;
    integer i;

    function [AW-1:0] waddr;
        input [AW-1:0] base;
        input [`IOCBD_WIDX_W-1:0] idx;
        begin
            waddr = base + {{(AW-`IOCBD_WIDX_W){1'b0}}, idx};
        end
    endfunction

    wire [AW-1:0] cmd_ptr = blk[`IOCBD_W_CMDP][AW-1:0];
    wire [AW-1:0] res_ptr = blk[`IOCBD_W_RESP][AW-1:0];
    wire [LW-1:0] cmd_len = blk[`IOCBD_W_LEN][`IOCBD_LEN_CMD_HI:`IOCBD_LEN_CMD_LO];
    wire [LW-1:0] res_len = blk[`IOCBD_W_LEN][`IOCBD_LEN_RES_HI:`IOCBD_LEN_RES_LO];
    wire [`IOCBD_WORD_W-1:0] self_ptr = blk[`IOCBD_W_SELF];

    wire cw_valid;
    wire cw_internal;
    wire cw_echo;
    wire [3:0] d_port;
    wire d_base;
    wire d_exp;
    wire [3:0] d_mod;
    wire [3:0] d_slot;
    wire d_bad;

    iocbd_cw_check u_cw (
        .control_word(blk[`IOCBD_W_CTRL][`IOCBD_CW_W-1:0]),
        .valid(cw_valid),
        .internal_operation(cw_internal),
        .echo(cw_echo)
    );

    iocbd_addr_dec u_ad (
        .link_address_word(blk[`IOCBD_W_ADDR]),
        .port(d_port),
        .base_card_select(d_base),
        .expansion_module_select(d_exp),
        .expansion_module_number(d_mod),
        .link_slot_select(d_slot),
        .malformed(d_bad)
    );

    wire in_ok = blk[`IOCBD_W_CTRL][`IOCBD_CW_INPUT];
    wire out_ok = blk[`IOCBD_W_CTRL][`IOCBD_CW_OUTPUT];

    assign busy = (state != S_IDLE);
    // Results are taken one word at a time; a held word blocks the next.
    assign res_ready = (state == S_RES) && !res_have;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            widx <= `IOCBD_W_CTRL;
            count <= {LW{1'b0}};
            cursor <= {AW{1'b0}};
            res_hold <= {`IOCBD_WORD_W{1'b0}};
            res_have <= 1'b0;
            done <= 1'b0;
            error_code <= `IOCBD_ERR_NONE;
            interrupt_sense <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= {AW{1'b0}};
            mem_wdata <= {`IOCBD_WORD_W{1'b0}};
            link_connect <= 1'b0;
            link_hang <= 1'b0;
            port <= 4'h0;
            base_card_select <= 1'b0;
            expansion_module_select <= 1'b0;
            expansion_module_number <= 4'h0;
            link_slot_select <= 4'h0;
            echo_command <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_data <= {`IOCBD_WORD_W{1'b0}};
            internal_code <= {`IOCBD_WORD_W{1'b0}};
            internal_start <= 1'b0;
            for (i = 0; i < 10; i = i + 1) begin
                blk[i] <= {`IOCBD_WORD_W{1'b0}};
            end
        end else begin
            done <= 1'b0;
            internal_start <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start) begin
                        widx <= `IOCBD_W_CTRL;
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= block_base;
                        error_code <= `IOCBD_ERR_NONE;
                        interrupt_sense <= 1'b0;
                        link_hang <= 1'b0;
                        state <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (mem_ack) begin
                        blk[widx] <= mem_rdata;
                        if (widx == `IOCBD_W_LINK) begin
                            // Command code lives behind the word 4 pointer.
                            mem_addr <= cmd_ptr;
                            state <= S_CODE;
                        end else begin
                            widx <= widx + 4'h1;
                            mem_addr <= waddr(block_base, widx + 4'h1);
                        end
                    end
                end
                S_CODE: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        internal_code <= mem_rdata;
                        state <= S_DECIDE;
                    end
                end
                S_DECIDE: begin
                    if (!cw_valid) begin
                        error_code <= `IOCBD_ERR_CMD;
                        state <= S_DONE;
                    end else if (cw_internal) begin
                        // Internal work: no link connect, no address use.
                        internal_start <= 1'b1;
                        state <= S_DONE;
                    end else if (d_bad) begin
                        error_code <= `IOCBD_ERR_ADDR;
                        state <= S_DONE;
                    end else if (!in_ok && !out_ok) begin
                        error_code <= `IOCBD_ERR_STATUS;
                        state <= S_DONE;
                    end else begin
                        link_connect <= 1'b1;
                        port <= d_port;
                        base_card_select <= d_base;
                        expansion_module_select <= d_exp && !d_base;
                        expansion_module_number <= d_mod;
                        link_slot_select <= (d_base || d_exp) ? 4'h0 : d_slot;
                        echo_command <= cw_echo;
                        cursor <= cmd_ptr;
                        count <= {LW{1'b0}};
                        mem_req <= 1'b1;
                        mem_addr <= cmd_ptr;
                        state <= S_CMD;
                    end
                end
                S_CMD: begin
                    if (mem_ack && mem_req) begin
                        mem_req <= 1'b0;
                        cmd_valid <= 1'b1;
                        cmd_data <= mem_rdata;
                    end
                    if (cmd_valid && cmd_ready) begin
                        cmd_valid <= 1'b0;
                        // Stop at the command length.
                        if (count + 16'h0001 >= cmd_len) begin
                            count <= {LW{1'b0}};
                            cursor <= res_ptr;
                            state <= S_RES;
                        end else begin
                            count <= count + 16'h0001;
                            cursor <= cursor + {{(AW-1){1'b0}}, 1'b1};
                            mem_req <= 1'b1;
                            mem_addr <= cursor + {{(AW-1){1'b0}}, 1'b1};
                        end
                    end
                end
                S_RES: begin
                    if (res_valid && !res_have) begin
                        if (count >= res_len || !link_status_ok) begin
                            // Overlong or unexpected: drop link, leave hung.
                            error_code <= `IOCBD_ERR_UNEXP;
                            link_connect <= 1'b0;
                            link_hang <= 1'b1;
                            state <= S_DONE;
                        end else begin
                            res_hold <= res_data;
                            res_have <= 1'b1;
                            mem_req <= 1'b1;
                            mem_we <= 1'b1;
                            mem_addr <= cursor;
                            mem_wdata <= res_data;
                            state <= S_RESWR;
                            count <= count + 16'h0001;
                            if (res_last) begin
                                link_connect <= 1'b0;
                            end
                        end
                    end
                end
                S_RESWR: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        res_have <= 1'b0;
                        cursor <= cursor + {{(AW-1){1'b0}}, 1'b1};
                        if (!link_connect) begin
                            // Masked status raises the sense.
                            interrupt_sense <= |(blk[`IOCBD_W_MASK] & state_result);
                            // Queue tail search starts at the word 8 head.
                            mem_req <= 1'b1;
                            mem_addr <= blk[`IOCBD_W_RESULT_QUEUE_HEAD_PTR][AW-1:0];
                            state <= S_TAIL;
                        end else begin
                            state <= S_RES;
                        end
                    end
                end
                S_TAIL: begin
                    if (mem_ack) begin
                        if (mem_rdata == `IOCBD_SELF_NULL) begin
                            // Empty queue: the head takes our self pointer.
                            mem_we <= 1'b1;
                            mem_wdata <= self_ptr;
                            state <= S_LINK;
                        end else begin
                            mem_addr <= waddr(mem_rdata[AW-1:0], `IOCBD_W_LINK);
                            state <= S_WALK;
                        end
                    end
                end
                S_WALK: begin
                    if (mem_ack) begin
                        if (mem_rdata == `IOCBD_SELF_NULL) begin
                            // Tail reached: its word 9 gets our self pointer.
                            mem_we <= 1'b1;
                            mem_wdata <= self_ptr;
                            state <= S_LINK;
                        end else begin
                            mem_addr <= waddr(mem_rdata[AW-1:0], `IOCBD_W_LINK);
                        end
                    end
                end
                S_LINK: begin
                    if (mem_ack) begin
                        // Our own word 9 becomes the null link; words 2, 3 stay.
                        mem_addr <= waddr(block_base, `IOCBD_W_LINK);
                        mem_wdata <= `IOCBD_SELF_NULL;
                        state <= S_MARK;
                    end
                end
                S_MARK: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    done <= 1'b1;
                    link_connect <= 1'b0;
                    cmd_valid <= 1'b0;
                    mem_req <= 1'b0;
                    mem_we <= 1'b0;
                    res_have <= 1'b0;
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // iocbd_top

// file: bench/iocbd_chk.sv
/* Port checker for the control block decoder top.
   Assumes it is bound to every iocbd_top instance. */
`timescale 1ns/1ps
`include "iocbd_defs.vh"
module iocbd_chk #(
    parameter AW = 20,
    parameter LW = 16
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [AW-1:0] block_base,
    input wire done,
    input wire [2:0] error_code,
    input wire mem_req,
    input wire mem_we,
    input wire mem_ack,
    input wire [AW-1:0] mem_addr,
    input wire cmd_valid,
    input wire cmd_ready,
    input wire [`IOCBD_WORD_W-1:0] cmd_data,
    input wire res_valid,
    input wire res_ready,
    input wire link_status_ok,
    input wire link_connect,
    input wire link_hang,
    input wire internal_start,
    input wire base_card_select,
    input wire expansion_module_select,
    input wire [3:0] link_slot_select
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_n);
property p_mem_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we); endproperty
a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped early");
property p_cmd_hold; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data); endproperty
a_cmd_hold: assert property (p_cmd_hold) else $error("command word dropped early");
property p_done_pulse; done |=> !done; endproperty
a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
property p_internal; internal_start |-> !link_connect && !cmd_valid; endproperty
a_internal: assert property (p_internal) else $error("internal op used the link");
property p_base; base_card_select |-> link_slot_select == 4'h0 && !expansion_module_select; endproperty
a_base: assert property (p_base) else $error("base card with slot or module");
property p_hang; res_valid && res_ready && !link_status_ok |-> ##[1:4] link_hang; endproperty
a_hang: assert property (p_hang) else $error("bad status did not hang link");
property p_hang_err; $rose(link_hang) |-> ##[0:2] error_code == 3'h3; endproperty
a_hang_err: assert property (p_hang_err) else $error("hang without status error");
property p_ro; mem_req && mem_we |-> mem_addr != block_base + 3 && mem_addr != block_base + 2; endproperty
a_ro: assert property (p_ro) else $error("write to self or header pointer");
endmodule // iocbd_chk
bind iocbd_top iocbd_chk #(.AW(AW), .LW(LW)) iocbd_chk_i (.*);

// file: bench/iocbd_far_model.sv
/* Far side model: word memory and a link processor that returns n_res words.
   Assumes the decoder's clock; slow stalls every other cycle. */
`timescale 1ns/1ps
`include "iocbd_defs.vh"
module iocbd_far_model (
    input wire sys_clk,
    input wire slow,
    input wire bad_status,
    input wire [3:0] n_res,
    input wire mem_req,
    input wire mem_we,
    input wire [19:0] mem_addr,
    input wire [47:0] mem_wdata,
    output reg mem_ack,
    output reg [47:0] mem_rdata,
    input wire link_connect,
    input wire cmd_valid,
    output reg cmd_ready,
    input wire res_ready,
    output wire res_valid,
    output wire [47:0] res_data,
    output wire res_last,
    output wire link_status_ok
);
reg [47:0] mem [0:255];
reg [3:0] sent;
reg tick;
integer j;
initial begin
    for (j = 0; j < 256; j = j + 1) mem[j] = 48'h0;
    mem_ack = 0; mem_rdata = 0; cmd_ready = 0; sent = 0; tick = 0;
end
always @(posedge sys_clk) begin
    tick <= ~tick;
    mem_ack <= mem_req && !mem_ack && (!slow || tick);
    // Read data lives only in the ack cycle; it is inverted after so stale use shows.
    if (mem_req && !mem_ack && (!slow || tick)) begin
        if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
        mem_rdata <= mem[mem_addr[7:0]];
    end else mem_rdata <= ~mem_rdata;
    cmd_ready <= link_connect && (!slow || tick);
    if (!link_connect) sent <= 4'h0;
    else if (res_valid && res_ready) sent <= sent + 4'h1;
end
assign res_valid = link_connect && sent < n_res;
assign res_data = res_valid ? 48'hA0 + sent : ~(48'hA0 + sent);
assign res_last = sent == n_res - 4'h1;
assign link_status_ok = !(bad_status && res_last);
endmodule // iocbd_far_model

// file: bench/io_control_block_decode_tb.sv
/* Self-checking bench for the control block decoder.
   Assumes the far side model and the bound port checker. */
`timescale 1ns/1ps
`include "iocbd_defs.vh"
`define FM iocbd_far_model_i.mem
module io_control_block_decode_tb;
reg sys_clk = 0;
reg rst_n = 0;
reg start = 0;
reg slow = 0;
reg bad_status = 0;
reg [3:0] n_res = 4'h2;
reg [19:0] block_base = 20'h10;
reg [47:0] state_result = 48'h0;
reg [47:0] qhead = 48'h0;
reg [47:0] aw;
reg [17:0] pat;
reg [15:0] seed = 16'h002B;
integer n_fail = 0;
integer comparisons = 0;
integer starts = 0;
integer conn = 0;
integer i;
localparam [89:0] PATS = {18'h00930, 18'h00420, 18'h00950, 18'h00440, 18'h00460};
wire busy, done, interrupt_sense, mem_req, mem_we, mem_ack, link_connect, link_hang;
wire base_card_select, expansion_module_select, echo_command, cmd_valid, cmd_ready;
wire res_valid, res_last, res_ready, link_status_ok, internal_start;
wire [2:0] error_code;
wire [19:0] mem_addr;
wire [3:0] port, expansion_module_number, link_slot_select;
wire [47:0] mem_wdata, mem_rdata, cmd_data, res_data, internal_code;
iocbd_top #(.AW(20), .LW(16)) iocbd_top_i (.*);
iocbd_far_model iocbd_far_model_i (.*);
always #2 sys_clk = ~sys_clk;
always @(posedge sys_clk) begin
    if (internal_start) starts = starts + 1;
    if (link_connect) conn = conn + 1;
end
function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction
task chk(input [8*8-1:0] what, input [47:0] exp, input [47:0] got);
    begin
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %0s: expected %h seen %h", what, exp, got);
        end
    end
endtask
task wrap_up;
    begin
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
endtask
// Builds one block at 0x10 with code at 0x40, results at 0x60, queue head at 0x80.
task run(input [17:0] cw, input [47:0] a, input [3:0] nr, input bad);
    integer k;
    begin
        seed = lfsr(seed);
        `FM[8'h10] = {30'h0, cw | {seed[9:8], 15'h0, seed[3]}};
        `FM[8'h11] = a;
        `FM[8'h12] = 48'h77;
        `FM[8'h13] = 48'h10;
        `FM[8'h14] = 48'h40;
        `FM[8'h15] = 48'h60;
        `FM[8'h16] = 48'h0002_0000_0002;
        `FM[8'h17] = {3{seed}};
        `FM[8'h18] = 48'h80;
        `FM[8'h19] = 48'h5;
        `FM[8'h40] = {seed, ~seed, seed};
        `FM[8'h80] = qhead;
        state_result = {~seed, seed ^ 16'h00FF, ~seed};
        n_res = nr; bad_status = bad; starts = 0; conn = 0;
        @(negedge sys_clk) start = 1;
        @(negedge sys_clk) start = 0;
        k = 0;
        while (done !== 1'b1 && k < 500) begin
            @(posedge sys_clk);
            #1 k = k + 1;
        end
        chk("finish", 48'h1, done);
    end
endtask
initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1;
    run(18'h00402, 48'h0, 4'h2, 1'b0);
    chk("code", `FM[8'h40], internal_code);
    chk("istart", 48'h1, starts);
    chk("conn", 48'h0, conn);
    for (i = 0; i < 5; i = i + 1) begin
        slow = i[0];
        pat = PATS[i*18 +: 18];
        aw = {28'h0, seed[15:12] & 4'h7, seed[11], seed[10], 6'h0, 1'b0, seed[6:4], 1'b0, seed[2:0]};
        run(pat, aw, 4'h2, 1'b0);
        chk("err", 48'h0, error_code);
        chk("port", aw[19:16], port);
        chk("base", aw[15], base_card_select);
        chk("exp", aw[14] & ~aw[15], expansion_module_select);
        if (aw[14] & ~aw[15]) chk("module", aw[7:4], expansion_module_number);
        chk("slot", (aw[15] | aw[14]) ? 48'h0 : aw[3:0], link_slot_select);
        chk("echo", pat == 18'h00460, echo_command);
        chk("istart", 48'h0, starts);
        chk("result", 48'hA0, `FM[8'h60]);
        chk("tail", 48'h10, `FM[8'h80]);
        chk("ownlink", 48'h0, `FM[8'h19]);
        chk("self", 48'h10, `FM[8'h13]);
        chk("command_queue_header_ptr", 48'h77, `FM[8'h12]);
        chk("irq", |(`FM[8'h17] & state_result), interrupt_sense);
    end
    run(18'h3FFFF, 48'h0, 4'h2, 1'b0);
    chk("err", 48'h1, error_code);
    chk("conn", 48'h0, conn);
    qhead = 48'h30;
    `FM[8'h39] = 48'h0;
    run(18'h00930, 48'h1, 4'h2, 1'b0);
    chk("walk", 48'h10, `FM[8'h39]);
    chk("head", 48'h30, `FM[8'h80]);
    qhead = 48'h0;
    run(18'h00460, 48'h100000, 4'h2, 1'b0);
    chk("err", 48'h4, error_code);
    run(18'h00460, 48'h8, 4'h2, 1'b0);
    chk("err", 48'h4, error_code);
    run(18'h00460, 48'h1, 4'h3, 1'b0);
    chk("err", 48'h3, error_code);
    chk("hang", 48'h1, link_hang);
    run(18'h00A30, 48'h2, 4'h2, 1'b1);
    chk("err", 48'h3, error_code);
    wrap_up;
end
initial begin
    #40000;
    n_fail = n_fail + 1;
    wrap_up;
end
endmodule // io_control_block_decode_tb
